// [sbst_jtag_tester.sv]
`timescale 1ns/1ns
// ************************************************************
// Tester at the far side of the test port
// ************************************************************
module sbst_jtag_tester (
  input wire clk,
  input wire tdo_ff,
  input wire tdo_oe_n_ff,
  output logic tck,
  output logic tms,
  output logic tdi
);
  logic last_ff;
  wire tdo_line;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    last_ff = 1'b0;
  end
  always @(posedge clk) begin
    if (!tdo_oe_n_ff) begin
      last_ff <= tdo_ff;
    end
  end
  // Released line shows the inverse of its last driven level
  assign tdo_line = tdo_oe_n_ff ? ~last_ff : tdo_ff;
  task automatic step(input logic m, input logic d, output logic o,
    output logic e);
    @(posedge clk);
    tms <= m;
    tdi <= d;
    repeat (7) @(posedge clk);
    o = tdo_line;
    e = tdo_oe_n_ff;
    tck <= 1'b1;
    repeat (8) @(posedge clk);
    tck <= 1'b0;
  endtask
  task automatic reset5;
    logic o;
    logic e;
    repeat (5) step(1'b1, 1'b1, o, e);
  endtask
  task automatic scan(input logic ir, input int n, input logic [129:0] din,
    output logic [129:0] dout, output logic oe_any);
    logic o;
    logic e;
    int i;
    step(1'b0, 1'b1, o, e);
    step(1'b1, 1'b1, o, e);
    if (ir) begin
      step(1'b1, 1'b1, o, e);
    end
    step(1'b0, 1'b1, o, e);
    step(1'b0, 1'b1, o, e);
    dout = '0;
    oe_any = 1'b0;
    for (i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o, e);
      dout[i] = o;
      oe_any = oe_any | e;
    end
    step(1'b0, 1'b1, o, e);
  endtask
  task automatic fin;
    logic o;
    logic e;
    step(1'b1, 1'b1, o, e);
    step(1'b1, 1'b1, o, e);
    step(1'b0, 1'b1, o, e);
    repeat (4) @(posedge clk);
  endtask
endmodule // sbst_jtag_tester

// [sbst_map.vh]
`ifndef SBST_MAP_VH
`define SBST_MAP_VH

// ************************************************************
// Instruction codes
// ************************************************************
`define SBST_IR_W 3
`define SBST_IR_EXTEST 3'h0
`define SBST_IR_IDCODE 3'h1
`define SBST_IR_SAMPLEZ 3'h2
`define SBST_IR_RSV0 3'h3
`define SBST_IR_SAMPLE 3'h4
`define SBST_IR_RSV1 3'h5
`define SBST_IR_RSV2 3'h6
`define SBST_IR_BYPASS 3'h7
`define SBST_IR_RESET `SBST_IR_IDCODE

// ************************************************************
// Data register lengths
// ************************************************************
`define SBST_ID_W 32
`define SBST_BSR_W 129
`define SBST_RING_W 128
`define SBST_BSR_INT 128
`define SBST_TLR_ONES 5

// ************************************************************
// Register map
// ************************************************************
`define SBST_OFS_STATUS 4'h0
`define SBST_OFS_CTRL 4'h4
`define SBST_ST_STATE_LSB 0
`define SBST_ST_IR_LSB 16
`define SBST_ST_EXTEST 19
`define SBST_ST_SAMPLEZ 20
`define SBST_ST_MEMOP 21
`define SBST_CTRL_SOFT_RST 0
`define SBST_CTRL_RESET 32'h00000000

`endif

// [sbst_tap.v]
`timescale 1ns/1ns
`include "sbst_map.vh"

// How it works
// - Controller is a sixteen-state machine steering the test registers.
// - State moves on each rising test clock edge, chosen by mode select.
// - Power-up reset places the controller in Test-Logic-Reset.
// - Five or more rising edges with mode select high reach Test-Logic-Reset.
// - Serial input is taken only in Shift-IR or Shift-DR.
// - Serial output driven only in Shift-IR or Shift-DR, else released.
// - Shift on rising edge, new serial output from the following falling edge.
// - Three-bit instruction register sits in the serial path during Shift-IR.
// - Instruction loads 001 at reset, in Test-Logic-Reset and Capture-IR.
// - Shifted instruction becomes active only at Update-IR.
// - Codes 000, 010, 100 capture and shift the boundary register.
// - Under code 000 output cells drive data, valid and echo clock pins.
// - Under code 000 new cell values reach pins only at Update-DR.
// - Termination disabled while code 000 or 010 is active.
// - Code 010 forces read data drivers to high impedance.
// - Code 001 captures a fixed identity and shifts the identity register.
// - Code 111 captures 0 into bypass and shifts it.
// - Bypass register is one bit.
// - Identity is 32 bits, bit 0 one, enters at MSB, leaves at LSB.
// - Boundary register 129 bits; internal cell captures 1, gates data drivers under code 000.
// - Memory keeps working except under codes 000 and 010.
module sbst_tap #(
  // Identity value is arbitrary; bit 0 must stay one
  parameter [31:0] ID_VALUE = 32'h1234_5A01
) (
  input wire clk,
  input wire rst_n,
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo_ff,
  output reg tdo_oe_n_ff,
  input wire [`SBST_RING_W-1:0] ring_in,
  input wire [`SBST_RING_W-1:0] func_out,
  output reg [`SBST_RING_W-1:0] ring_out_ff,
  output reg q_oe_n_ff,
  output reg odt_off_ff,
  output reg mem_op_en_ff,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest
);

  // ************************************************************
  // Controller states
  // ************************************************************
  localparam [15:0] S_TLR = 16'h0001;
  localparam [15:0] S_RTI = 16'h0002;
  localparam [15:0] S_SEL_DR = 16'h0004;
  localparam [15:0] S_CAP_DR = 16'h0008;
  localparam [15:0] S_SH_DR = 16'h0010;
  localparam [15:0] S_EX1_DR = 16'h0020;
  localparam [15:0] S_PAU_DR = 16'h0040;
  localparam [15:0] S_EX2_DR = 16'h0080;
  localparam [15:0] S_UPD_DR = 16'h0100;
  localparam [15:0] S_SEL_IR = 16'h0200;
  localparam [15:0] S_CAP_IR = 16'h0400;
  localparam [15:0] S_SH_IR = 16'h0800;
  localparam [15:0] S_EX1_IR = 16'h1000;
  localparam [15:0] S_PAU_IR = 16'h2000;
  localparam [15:0] S_EX2_IR = 16'h4000;
  localparam [15:0] S_UPD_IR = 16'h8000;

  // ************************************************************
  // Storage
  // ************************************************************
  reg tck_s1_ff;
  reg tck_s2_ff;
  reg tck_s3_ff;
  reg tms_s1_ff;
  reg tms_s2_ff;
  reg tdi_s1_ff;
  reg tdi_s2_ff;
  reg [`SBST_RING_W-1:0] ring_s1_ff;
  reg [`SBST_RING_W-1:0] ring_s2_ff;
  reg [15:0] state_ff;
  reg [15:0] nxt_state;
  reg [`SBST_IR_W-1:0] ir_shift_ff;
  reg [`SBST_IR_W-1:0] ir_active_ff;
  reg byp_ff;
  reg [`SBST_ID_W-1:0] id_shift_ff;
  reg [`SBST_BSR_W-1:0] bsr_shift_ff;
  reg [`SBST_BSR_W-1:0] bsr_upd_ff;
  reg soft_rst_ff;

  // ************************************************************
  // Test clock edges
  // ************************************************************
  // Third stage holds the previous level, one pulse per pin edge
  wire tck_rise = tck_s2_ff & ~tck_s3_ff;
  wire tck_fall = ~tck_s2_ff & tck_s3_ff;
  // Instruction register and serial drive reset in the controller's reset state or on a bus pulse
  wire tap_reset = (state_ff == S_TLR) | soft_rst_ff;

  // ************************************************************
  // Instruction decode
  // ************************************************************
  wire dec_extest = (ir_active_ff == `SBST_IR_EXTEST);
  wire dec_samplez = (ir_active_ff == `SBST_IR_SAMPLEZ);
  wire dec_sample = (ir_active_ff == `SBST_IR_SAMPLE);
  wire dec_idcode = (ir_active_ff == `SBST_IR_IDCODE);
  wire dec_bsr = dec_extest | dec_samplez | dec_sample;
  // Reserved codes fall through to the one-bit bypass path
  wire dec_byp = ~dec_bsr & ~dec_idcode;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Pins pass two stages before any logic reads them
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_s1_ff <= 1'b0;
      tck_s2_ff <= 1'b0;
      tck_s3_ff <= 1'b0;
      tms_s1_ff <= 1'b1;
      tms_s2_ff <= 1'b1;
      tdi_s1_ff <= 1'b1;
      tdi_s2_ff <= 1'b1;
      ring_s1_ff <= {`SBST_RING_W{1'b0}};
      ring_s2_ff <= {`SBST_RING_W{1'b0}};
    end else begin
      tck_s1_ff <= tck;
      tck_s2_ff <= tck_s1_ff;
      tck_s3_ff <= tck_s2_ff;
      tms_s1_ff <= tms;
      tms_s2_ff <= tms_s1_ff;
      tdi_s1_ff <= tdi;
      tdi_s2_ff <= tdi_s1_ff;
      ring_s1_ff <= ring_in;
      ring_s2_ff <= ring_s1_ff;
    end
  end

  // ************************************************************
  // Controller next state
  // ************************************************************
  // Mode select level picks the next state
  always @* begin
    nxt_state = S_TLR;
    case (state_ff)
      S_TLR: nxt_state = tms_s2_ff ? S_TLR : S_RTI;
      S_RTI: nxt_state = tms_s2_ff ? S_SEL_DR : S_RTI;
      S_SEL_DR: nxt_state = tms_s2_ff ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: nxt_state = tms_s2_ff ? S_EX1_DR : S_SH_DR;
      S_SH_DR: nxt_state = tms_s2_ff ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: nxt_state = tms_s2_ff ? S_UPD_DR : S_PAU_DR;
      S_PAU_DR: nxt_state = tms_s2_ff ? S_EX2_DR : S_PAU_DR;
      S_EX2_DR: nxt_state = tms_s2_ff ? S_UPD_DR : S_SH_DR;
      S_UPD_DR: nxt_state = tms_s2_ff ? S_SEL_DR : S_RTI;
      S_SEL_IR: nxt_state = tms_s2_ff ? S_TLR : S_CAP_IR;
      S_CAP_IR: nxt_state = tms_s2_ff ? S_EX1_IR : S_SH_IR;
      S_SH_IR: nxt_state = tms_s2_ff ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: nxt_state = tms_s2_ff ? S_UPD_IR : S_PAU_IR;
      S_PAU_IR: nxt_state = tms_s2_ff ? S_EX2_IR : S_PAU_IR;
      S_EX2_IR: nxt_state = tms_s2_ff ? S_UPD_IR : S_SH_IR;
      S_UPD_IR: nxt_state = tms_s2_ff ? S_SEL_DR : S_RTI;
      default: nxt_state = S_TLR;
    endcase
  end

  // ************************************************************
  // Controller state register
  // ************************************************************
  // Bus soft reset overrides any pending test clock edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= S_TLR;
    end else if (soft_rst_ff) begin
      state_ff <= S_TLR;
    end else if (tck_rise) begin
      state_ff <= nxt_state;
    end
  end

  // ************************************************************
  // Instruction register
  // ************************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_shift_ff <= `SBST_IR_RESET;
      ir_active_ff <= `SBST_IR_RESET;
    end else if (tap_reset) begin
      ir_shift_ff <= `SBST_IR_RESET;
      ir_active_ff <= `SBST_IR_RESET;
    end else if (tck_rise) begin
      // Capture-IR reloads the default code
      if (state_ff == S_CAP_IR) begin
        ir_shift_ff <= `SBST_IR_RESET;
      end else if (state_ff == S_SH_IR) begin
        ir_shift_ff <= {tdi_s2_ff, ir_shift_ff[`SBST_IR_W-1:1]};
      end
    // Active copy takes the shifted code only on the fall inside Update-IR
    end else if (tck_fall && state_ff == S_UPD_IR) begin
      ir_active_ff <= ir_shift_ff;
    end
  end

  // ************************************************************
  // Data registers
  // ************************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byp_ff <= 1'b0;
      id_shift_ff <= {`SBST_ID_W{1'b0}};
      bsr_shift_ff <= {`SBST_BSR_W{1'b0}};
    // Capture acts on the rise that leaves Capture-DR
    end else if (tck_rise && state_ff == S_CAP_DR) begin
      if (dec_byp) begin
        byp_ff <= 1'b0;
      end
      if (dec_idcode) begin
        id_shift_ff <= {ID_VALUE[`SBST_ID_W-1:1], 1'b1};
      end
      if (dec_bsr) begin
        bsr_shift_ff <= {1'b1, ring_s2_ff};
      end
    // Only the selected register shifts; input enters at the top
    end else if (tck_rise && state_ff == S_SH_DR) begin
      if (dec_byp) begin
        byp_ff <= tdi_s2_ff;
      end
      if (dec_idcode) begin
        id_shift_ff <= {tdi_s2_ff, id_shift_ff[`SBST_ID_W-1:1]};
      end
      if (dec_bsr) begin
        bsr_shift_ff <= {tdi_s2_ff, bsr_shift_ff[`SBST_BSR_W-1:1]};
      end
    end
  end

  // ************************************************************
  // Boundary update latch
  // ************************************************************
  // Update latch keeps pins steady while new cell values shift through
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bsr_upd_ff <= {`SBST_BSR_W{1'b0}};
    end else if (tck_fall && state_ff == S_UPD_DR && dec_bsr) begin
      bsr_upd_ff <= bsr_shift_ff;
    end
  end

  // ************************************************************
  // Serial output
  // ************************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo_ff <= 1'b0;
      tdo_oe_n_ff <= 1'b1;
    end else if (tap_reset) begin
      // Serial out keeps its level so it never moves with the clock high
      tdo_oe_n_ff <= 1'b1;
    end else if (tck_fall) begin
      // Enable follows the state seen at the falling edge
      tdo_oe_n_ff <= ~((state_ff == S_SH_IR) | (state_ff == S_SH_DR));
      if (state_ff == S_SH_IR) begin
        tdo_ff <= ir_shift_ff[0];
      end else if (state_ff == S_SH_DR) begin
        if (dec_bsr) begin
          tdo_ff <= bsr_shift_ff[0];
        end else if (dec_idcode) begin
          tdo_ff <= id_shift_ff[0];
        end else begin
          tdo_ff <= byp_ff;
        end
      end
    end
  end

  // ************************************************************
  // Pin control
  // ************************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ring_out_ff <= {`SBST_RING_W{1'b0}};
      q_oe_n_ff <= 1'b0;
      odt_off_ff <= 1'b0;
      mem_op_en_ff <= 1'b1;
    end else begin
      // Output cells reach the pins only under the external test code
      if (dec_extest) begin
        ring_out_ff <= bsr_upd_ff[`SBST_RING_W-1:0];
      end else begin
        ring_out_ff <= func_out;
      end
      // Internal cell gates the read data drivers under external test
      if (dec_extest) begin
        q_oe_n_ff <= ~bsr_upd_ff[`SBST_BSR_INT];
      end else begin
        q_oe_n_ff <= dec_samplez;
      end
      // Termination and memory access both stop under 000 and 010
      odt_off_ff <= dec_extest | dec_samplez;
      mem_op_en_ff <= ~(dec_extest | dec_samplez);
    end
  end

  // ************************************************************
  // Avalon-MM slave
  // ************************************************************
  wire avs_req = avs_read | avs_write;
  wire avs_take = avs_req & ~avs_waitrequest;

  // Each access waits one cycle, then completes
  // Soft reset is a single-cycle pulse
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      soft_rst_ff <= 1'b0;
    end else begin
      soft_rst_ff <= 1'b0;
      if (avs_take) begin
        avs_waitrequest <= 1'b1;
        if (avs_write && avs_address == `SBST_OFS_CTRL) begin
          soft_rst_ff <= avs_writedata[`SBST_CTRL_SOFT_RST];
        end
      end else if (avs_req) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= 32'h00000000;
        // Status: one-hot state, active code, mode flags; others read zero
        if (avs_read && avs_address == `SBST_OFS_STATUS) begin
          avs_readdata[`SBST_ST_STATE_LSB+15:`SBST_ST_STATE_LSB] <= state_ff;
          avs_readdata[`SBST_ST_IR_LSB+2:`SBST_ST_IR_LSB] <= ir_active_ff;
          avs_readdata[`SBST_ST_EXTEST] <= dec_extest;
          avs_readdata[`SBST_ST_SAMPLEZ] <= dec_samplez;
          avs_readdata[`SBST_ST_MEMOP] <= mem_op_en_ff;
        end
      end
    end
  end

endmodule // sbst_tap

// [sbst_tap_asserts.sv]
`timescale 1ns/1ns
// ************************************************************
// Port checker
// ************************************************************
module sbst_tap_chk (
  input wire clk,
  input wire rst_n,
  input wire tck,
  input wire tdo_ff,
  input wire tdo_oe_n_ff,
  input wire q_oe_n_ff,
  input wire odt_off_ff,
  input wire mem_op_en_ff,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_wait_one_cycle: assert property (s_req |=> s_ack)
    else $error("bus answer not one cycle");
  a_wait_idle_high: assert property (!(avs_read || avs_write) |=>
    avs_waitrequest) else $error("waitrequest low when idle");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest &&
    avs_address != 4'h0 |-> avs_readdata == 32'h00000000)
    else $error("nonzero read data");
  a_readdata_stands: assert property (!(avs_read || avs_write) |=>
    $stable(avs_readdata)) else $error("read data moved");
  a_tdo_on_fall: assert property ($changed(tdo_ff) |-> !tck)
    else $error("serial out moved with test clock high");
  a_oe_on_fall: assert property ($changed(tdo_oe_n_ff) |-> !tck)
    else $error("serial drive moved with test clock high");
  a_odt_memop: assert property (odt_off_ff != mem_op_en_ff)
    else $error("termination and memory enable disagree");
  a_qz_memop: assert property (q_oe_n_ff |-> !mem_op_en_ff)
    else $error("data drivers off in normal mode");
endmodule // sbst_tap_chk

// [sbst_tap_tb.sv]
`timescale 1ns/1ns
`include "sbst_map.vh"
// ************************************************************
// Bench
// ************************************************************
module sbst_tap_tb;
  // Identity value is arbitrary
  localparam logic [31:0] TB_ID = 32'h0F0FA5C3;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  wire tck, tms, tdi, tdo_ff, tdo_oe_n_ff, q_oe_n_ff, odt_off_ff;
  wire mem_op_en_ff, avs_waitrequest;
  wire [127:0] ring_out_ff;
  wire [31:0] avs_readdata;
  logic [127:0] ring_in = {8{16'hC3A5}};
  logic [127:0] func_out = {8{16'h5A3C}};
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [129:0] dout;
  logic oe;
  logic [31:0] q;
  always #5 clk = ~clk;
  sbst_tap #(.ID_VALUE(TB_ID)) i_sbst_tap (.clk, .rst_n, .tck, .tms, .tdi,
    .tdo_ff, .tdo_oe_n_ff, .ring_in, .func_out, .ring_out_ff, .q_oe_n_ff,
    .odt_off_ff, .mem_op_en_ff, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest);
  sbst_jtag_tester i_sbst_jtag_tester (.clk, .tdo_ff, .tdo_oe_n_ff, .tck,
    .tms, .tdi);
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch = n_mismatch + 1;
      tally_and_finish;
    end
  end
  task automatic chk(input string nm, input logic [129:0] s,
    input logic [129:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a,
    input logic [31:0] d);
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  function automatic logic [31:0] st_exp(input int s, input logic [2:0] c);
    st_exp = (32'h1 << s) | {10'h0, !(c == 3'h0 || c == 3'h2),
      c == 3'h2, c == 3'h0, c, 16'h0};
  endfunction
  task automatic load_ir(input logic [2:0] c, input logic [2:0] old);
    i_sbst_jtag_tester.scan(1'b1, 3, {127'h0, c}, dout, oe);
    chk("ir_capture", dout[2:0], `SBST_IR_IDCODE);
    chk("ir_oe_n", oe, 1'b0);
    bus(1'b0, `SBST_OFS_STATUS, 32'h0);
    chk("ir_pause", q, st_exp(13, old));
    i_sbst_jtag_tester.fin;
    bus(1'b0, `SBST_OFS_STATUS, 32'h0);
    chk("ir_active", q, st_exp(1, c));
  endtask
  task automatic t_reset;
    bus(1'b0, `SBST_OFS_STATUS, 32'h0);
    chk("rst_status", q, st_exp(0, `SBST_IR_IDCODE));
    chk("rst_oe_n", tdo_oe_n_ff, 1'b1);
    bus(1'b1, 4'hC, 32'hFFFFFFFF);
    bus(1'b0, 4'hC, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_codes;
    logic [129:0] din;
    logic [129:0] m;
    logic [127:0] pre;
    logic [2:0] prev;
    logic [3:0] k;
    int n;
    din = {1'b0, {8{16'h9C6B}}, 1'b1};
    prev = `SBST_IR_IDCODE;
    for (k = 4'h0; k < 4'h8; k++) begin
      if (k == 4'h3 || k == 4'h5 || k == 4'h6) continue;
      n = (k == 0 || k == 2 || k == 4) ? 129 : (k == 1) ? 32 : 1;
      load_ir(k[2:0], prev);
      pre = ring_out_ff;
      i_sbst_jtag_tester.scan(1'b0, n + 1, din, dout, oe);
      chk("dr_oe_n", oe, 1'b0);
      m = (130'h1 << (n + 1)) - 130'h1;
      chk("dr_out", dout & m, (130'h1 << n) | (k == 1 ? TB_ID :
        n == 129 ? {1'b1, ring_in} : 130'h0));
      chk("dr_len", dout[n], 1'b1);
      chk("pins_pause", ring_out_ff, pre);
      i_sbst_jtag_tester.fin;
      chk("pins", ring_out_ff, k == 0 ? din[128:1] : func_out);
      chk("q_oe_n", q_oe_n_ff, k == 0 ? !din[129] : k == 2);
      chk("odt_off", odt_off_ff, k == 0 || k == 2);
      chk("mem_op", mem_op_en_ff, !(k == 0 || k == 2));
      prev = k[2:0];
    end
    $display("t_codes done");
  endtask
  task automatic t_tlr;
    i_sbst_jtag_tester.scan(1'b0, 2, 130'h3, dout, oe);
    i_sbst_jtag_tester.reset5;
    bus(1'b0, `SBST_OFS_STATUS, 32'h0);
    chk("tms_reset", q, st_exp(0, `SBST_IR_IDCODE));
    load_ir(`SBST_IR_BYPASS, `SBST_IR_IDCODE);
    bus(1'b1, `SBST_OFS_CTRL, 32'h1);
    bus(1'b0, `SBST_OFS_STATUS, 32'h0);
    chk("soft_reset", q, st_exp(0, `SBST_IR_IDCODE));
    $display("t_tlr done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_codes;
    t_tlr;
    tally_and_finish;
  end
endmodule // sbst_tap_tb
bind sbst_tap sbst_tap_chk i_chk (.clk, .rst_n, .tck, .tdo_ff, .tdo_oe_n_ff,
  .q_oe_n_ff, .odt_off_ff, .mem_op_en_ff, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest);
